// [strobe_map.svh]
`ifndef STROBE_MAP_SVH
`define STROBE_MAP_SVH
`define DATA_WIDTH 16
`define FIFO_DEPTH 16
`define CLK_PERIOD_NS 100
`define READY_DELAY_NS 1000
`define READY_DELAY_CYC ((`READY_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define IRQ_PULSE_NS 500
`define IRQ_PULSE_CYC ((`IRQ_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// [strobe_pkg.sv]
package strobe_pkg;
   typedef enum logic [1:0] {
      memory_card_mode,
      io_card_mode,
      ide_mode
   } card_mode_t;
   typedef struct packed {
      logic io_read_strobe_n;
      logic io_write_strobe_n;
      logic output_enable_n;
      logic dma_read_strobe_n;
      logic dma_write_strobe_n;
      logic dma_grant_n;
      logic taskfile_select_n;
      logic ctrl_block_select_n;
      logic card_select_n;
   } host_strobes_t;
   typedef struct packed {
      logic taskfile_read;
      logic ctrl_block_read;
      logic attr_read;
      logic common_read;
      logic io_read;
   } read_kind_t;
endpackage

// [sync_2ff.sv]
module sync_2ff #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_reg <= INIT;
         sync_out <= INIT;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule

// [word_fifo.sv]
module word_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0] count_reg;
   wire logic push = in_valid && in_ready;
   wire logic pop = out_valid && out_ready;
   assign in_ready = (count_reg != DEPTH[AW:0]);
   assign out_valid = (count_reg != '0);
   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end
   // read data registered; shows head word whenever not empty, once that word has been stored for one clock
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         out_data <= '0;
      end else if (pop || !out_valid) begin
         out_data <= mem[pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg];
      end else begin
         out_data <= mem[rd_ptr_reg];
      end
   end
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         wr_ptr_reg <= wr_ptr_reg + AW'(push);
         rd_ptr_reg <= rd_ptr_reg + AW'(pop);
         count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// [card_host_strobe_handshake.sv]
`include "strobe_map.svh"

module card_host_strobe_handshake
   import strobe_pkg::*;
#(
   parameter int DATA_WIDTH = `DATA_WIDTH,
   parameter int FIFO_DEPTH = `FIFO_DEPTH,
   parameter int READY_DELAY_CYC = `READY_DELAY_CYC,
   parameter int IRQ_PULSE_CYC = `IRQ_PULSE_CYC
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic reset_held_at_powerup,
   input wire host_strobes_t host_pins,
   input wire logic [DATA_WIDTH-1:0] host_data_in,
   input wire logic device_selected,
   input wire logic io_addr_hit,
   input wire logic io_configured,
   input wire logic level_irq_mode,
   input wire logic irq_event,
   input wire logic busy_in,
   input wire logic [DATA_WIDTH-1:0] read_data,
   input wire logic dma_in_valid,
   output logic dma_in_ready,
   input wire logic [DATA_WIDTH-1:0] dma_in_data,
   input wire logic dma_to_host,
   input wire logic dma_active,
   input wire logic dma_more_data,
   output logic [DATA_WIDTH-1:0] dma_out_data,
   output logic dma_out_valid,
   output logic io_read_ack_n,
   output logic io_read_ack_oe,
   output logic dma_request,
   output logic dma_request_oe,
   output logic ready_busy_n,
   output logic [DATA_WIDTH-1:0] host_data_out,
   output logic host_data_oe,
   output logic [DATA_WIDTH-1:0] write_data,
   output logic write_strobe,
   output logic write_to_taskfile,
   output logic write_to_ctrl_block,
   output read_kind_t read_kind,
   output card_mode_t card_mode
);
   host_strobes_t pins_sync;
   logic [DATA_WIDTH-1:0] data_sync;
   logic io_write_strobe_n_prev_reg;
   logic dmaw_prev_reg;
   logic dmar_prev_reg;
   logic mode_latched_reg;
   logic [$clog2(READY_DELAY_CYC+1)-1:0] ready_cnt_reg;
   logic [$clog2(IRQ_PULSE_CYC+1)-1:0] irq_cnt_reg;
   logic irq_level_reg;
   logic never_busy_reg;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [DATA_WIDTH-1:0] fifo_out_data;
   logic fifo_in_ready;
   card_mode_t mode_next;

   // one clock of history per strobe is enough to find its edges
   function automatic logic rose_edge(input logic prev_n, input logic now_n);
      return !prev_n && now_n;
   endfunction

   function automatic logic fell_edge(input logic prev_n, input logic now_n);
      return prev_n && !now_n;
   endfunction

   sync_2ff #(.WIDTH($bits(host_strobes_t)), .INIT('1)) u_pin_sync (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .async_in(host_pins),
      .sync_out(pins_sync)
   );
   sync_2ff #(.WIDTH(DATA_WIDTH), .INIT('0)) u_data_sync (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .async_in(host_data_in),
      .sync_out(data_sync)
   );

   // dma words from the controller toward the host pass a fifo
   word_fifo #(.WIDTH(DATA_WIDTH), .DEPTH(FIFO_DEPTH)) u_dma_fifo (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .in_valid(dma_in_valid),
      .in_ready(fifo_in_ready),
      .in_data(dma_in_data),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );

   // mode is sampled until the latch closes after reset release; later only a non-ide card moving to io_card_mode is taken
   assign mode_next = !pins_sync.output_enable_n ? ide_mode :
                      io_configured ? io_card_mode : memory_card_mode;

   wire logic is_ide = (card_mode == ide_mode);
   wire logic is_io = (card_mode == io_card_mode);
   wire logic io_path = is_ide || is_io;
   wire logic dma_on = is_ide && dma_active;
   // grant only counts while dma is in progress
   wire logic grant = dma_on && !pins_sync.dma_grant_n;
   // chip selects must stay negated under dma
   wire logic cs_any = !pins_sync.taskfile_select_n ||
                       !pins_sync.ctrl_block_select_n;
   wire logic ide_tf = is_ide && !pins_sync.taskfile_select_n;
   wire logic ide_cb = is_ide && !pins_sync.ctrl_block_select_n;
   wire logic pc_sel = !is_ide && !pins_sync.card_select_n;
   wire logic io_rd = io_path && !pins_sync.io_read_strobe_n &&
                      (is_ide ? (ide_tf || ide_cb) : pc_sel);
   wire logic io_ack = is_io && pc_sel && io_addr_hit &&
                       !pins_sync.io_read_strobe_n;
   wire logic oe_rd = !is_ide && pc_sel && !pins_sync.output_enable_n;
   wire logic io_write_strobe_n_edge = rose_edge(io_write_strobe_n_prev_reg,
                                    pins_sync.io_write_strobe_n);
   wire logic dmar_edge = fell_edge(dmar_prev_reg,
                                    pins_sync.dma_read_strobe_n);
   wire logic dmaw_edge = rose_edge(dmaw_prev_reg,
                                    pins_sync.dma_write_strobe_n);
   wire logic io_write_strobe_n_rise = io_path && io_write_strobe_n_edge;
   // dma edges count only under grant with both selects negated
   wire logic dmar_fall = grant && !cs_any && dmar_edge;
   wire logic dmaw_rise = grant && !cs_any && dmaw_edge;
   wire logic irq_start = irq_event && !irq_level_reg;
   wire logic mode_take = !mode_latched_reg ||
                          (card_mode != ide_mode && mode_next == io_card_mode);
   wire logic host_read = io_rd || oe_rd || dmar_fall;
   wire logic ready_done = (ready_cnt_reg == '0);
   wire logic irq_pulse_on = (irq_cnt_reg != '0);
   wire logic io_irq_n = !(level_irq_mode ? irq_level_reg
                                          : irq_pulse_on);
   wire logic ide_irq = irq_level_reg;
   wire logic pin_level = never_busy_reg ? 1'b1 :
                          !ready_done ? 1'b0 :
                          is_ide ? ide_irq :
                          is_io ? io_irq_n :
                          !busy_in;
   wire logic req_next = dma_on && dma_more_data &&
                         (dma_to_host ? fifo_out_valid : 1'b1) &&
                         !grant;
   wire read_kind_t kind_next = '{
      taskfile_read: io_rd && ide_tf,
      ctrl_block_read: io_rd && ide_cb,
      attr_read: oe_rd,
      common_read: oe_rd && !is_io,
      io_read: io_rd && !is_ide
   };

   assign fifo_out_ready = dmar_fall && dma_to_host;
   assign dma_in_ready = fifo_in_ready;

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         io_write_strobe_n_prev_reg <= 1'b1;
         dmaw_prev_reg <= 1'b1;
         dmar_prev_reg <= 1'b1;
      end else begin
         io_write_strobe_n_prev_reg <= pins_sync.io_write_strobe_n;
         dmaw_prev_reg <= pins_sync.dma_write_strobe_n;
         dmar_prev_reg <= pins_sync.dma_read_strobe_n;
      end
   end

   // strap-like sampling happens on the first clocked edges after release
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         card_mode <= memory_card_mode;
      end else if (mode_take) begin
         card_mode <= mode_next;
      end
   end

   // latch closes once the boot count ends, freezing the mode strap
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         mode_latched_reg <= 1'b0;
      end else begin
         mode_latched_reg <= ready_done;
      end
   end

   // read until the latch closes; a reset pin that moves later has no say here
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         never_busy_reg <= 1'b0;
      end else if (!mode_latched_reg) begin
         never_busy_reg <= reset_held_at_powerup;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         ready_cnt_reg <= ($clog2(READY_DELAY_CYC+1))'(READY_DELAY_CYC);
      end else if (!ready_done) begin
         ready_cnt_reg <= ready_cnt_reg - 1'b1;
      end
   end

   // level irq holds until the source drops; pulse irq is a fixed width
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_level_reg <= 1'b0;
      end else begin
         irq_level_reg <= irq_event;
      end
   end

   // pulse width is fixed; a source that stays high does not restart it
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_cnt_reg <= '0;
      end else if (irq_start) begin
         irq_cnt_reg <= ($clog2(IRQ_PULSE_CYC+1))'(IRQ_PULSE_CYC);
      end else if (irq_pulse_on) begin
         irq_cnt_reg <= irq_cnt_reg - 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         dma_request <= 1'b0;
      end else begin
         dma_request <= req_next;
      end
   end

   // enable follows ide mode and selection only, so a deselected device lets go on the next clock
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         dma_request_oe <= 1'b0;
      end else begin
         dma_request_oe <= is_ide && device_selected;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         io_read_ack_n <= 1'b1;
         io_read_ack_oe <= 1'b0;
      end else begin
         io_read_ack_n <= !io_ack;
         io_read_ack_oe <= is_io && pc_sel;
      end
   end

   // reset value is low so the pin reads busy from the first edge
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         ready_busy_n <= 1'b0;
      end else begin
         ready_busy_n <= pin_level;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         host_data_oe <= 1'b0;
      end else begin
         host_data_oe <= host_read;
      end
   end

   // data hold their last value between reads; only the enable drops
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         host_data_out <= '0;
      end else if (dmar_fall) begin
         host_data_out <= fifo_out_data;
      end else if (host_read) begin
         host_data_out <= read_data;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         read_kind <= '0;
      end else begin
         read_kind <= kind_next;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         write_strobe <= 1'b0;
         write_to_taskfile <= 1'b0;
         write_to_ctrl_block <= 1'b0;
      end else begin
         write_strobe <= io_write_strobe_n_rise;
         write_to_taskfile <= io_write_strobe_n_rise && ide_tf;
         write_to_ctrl_block <= io_write_strobe_n_rise && ide_cb;
      end
   end

   // the synced data bus settled long before the trailing edge arrives
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         write_data <= '0;
      end else if (io_write_strobe_n_rise) begin
         write_data <= data_sync;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         dma_out_valid <= 1'b0;
      end else begin
         dma_out_valid <= dmaw_rise && !dma_to_host;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         dma_out_data <= '0;
      end else if (dmaw_rise) begin
         dma_out_data <= data_sync;
      end
   end
endmodule

// [card_host_strobe_handshake_monitor.sv]
module card_host_strobe_handshake_monitor
   import strobe_pkg::*;
#(
   parameter int READY_DELAY_CYC = 10
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic reset_held_at_powerup,
   input wire host_strobes_t host_pins,
   input wire logic device_selected,
   input wire logic io_addr_hit,
   input wire logic level_irq_mode,
   input wire logic irq_event,
   input wire logic busy_in,
   input wire logic dma_active,
   input wire logic io_read_ack_n,
   input wire logic dma_request,
   input wire logic dma_request_oe,
   input wire logic ready_busy_n,
   input wire logic write_strobe,
   input wire card_mode_t card_mode
);
   // slack for the pin synchronisers on top of the boot count
   localparam int BOOT_MAX = 4 * READY_DELAY_CYC + 8;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   ack_mem_idle_a: assert property (
      card_mode == memory_card_mode |-> io_read_ack_n)
      else $error("read ack active in memory mode");
   wr_mode_a: assert property (
      write_strobe |-> card_mode != memory_card_mode)
      else $error("write strobe in memory mode");
   wr_edge_a: assert property (
      card_mode == io_card_mode && io_addr_hit
      && $rose(host_pins.io_write_strobe_n) |-> ##[2:4] write_strobe)
      else $error("write not taken on trailing edge");
   req_ide_only_a: assert property (
      dma_request |-> card_mode == ide_mode)
      else $error("dma request outside ide mode");
   req_oe_sel_a: assert property (
      (!device_selected)[*4] |-> !dma_request_oe)
      else $error("dma request driven while not selected");
   grant_drop_a: assert property (
      (dma_active && !host_pins.dma_grant_n)[*6] |-> !dma_request)
      else $error("dma request held through grant");
   boot_busy_a: assert property (
      $rose(reset_n) && !reset_held_at_powerup && !busy_in
      && host_pins.output_enable_n
      |-> !ready_busy_n ##[1:BOOT_MAX] ready_busy_n)
      else $error("ready timing after reset wrong");
   mem_busy_a: assert property (
      (card_mode == memory_card_mode && busy_in
       && !reset_held_at_powerup)[*3] |-> !ready_busy_n)
      else $error("busy not shown on ready pin");
   io_irq_a: assert property (
      (card_mode == io_card_mode && level_irq_mode && irq_event)[*3]
      |-> !ready_busy_n)
      else $error("level irq not held low");
   ide_irq_a: assert property (
      (card_mode == ide_mode && irq_event)[*3] |-> ready_busy_n)
      else $error("ide irq not high");
endmodule

bind card_host_strobe_handshake card_host_strobe_handshake_monitor #(
   .READY_DELAY_CYC(READY_DELAY_CYC)
) u_monitor (
   .sys_clk(sys_clk), .reset_n(reset_n),
   .reset_held_at_powerup(reset_held_at_powerup), .host_pins(host_pins),
   .device_selected(device_selected), .io_addr_hit(io_addr_hit),
   .level_irq_mode(level_irq_mode), .irq_event(irq_event),
   .busy_in(busy_in), .dma_active(dma_active),
   .io_read_ack_n(io_read_ack_n), .dma_request(dma_request),
   .dma_request_oe(dma_request_oe), .ready_busy_n(ready_busy_n),
   .write_strobe(write_strobe), .card_mode(card_mode)
);

// [host_socket_model.sv]
module host_socket_model
   import strobe_pkg::*;
(
   input wire logic sys_clk,
   input wire logic io_read_ack_n,
   input wire logic [15:0] host_data_out,
   output host_strobes_t host_pins,
   output logic [15:0] host_data_in
);
   initial begin
      host_pins = '1;
      host_data_in = 16'h0000;
   end
   task automatic hold(input int i, input logic v);
      @(posedge sys_clk);
      host_pins[i] <= v;
   endtask
   // chip selects move only through hold, which the testbench uses to drop one during a refused dma cycle
   task automatic pulse(input int i, input logic [15:0] d,
                        output logic [15:0] q);
      @(posedge sys_clk);
      host_data_in <= d;
      host_pins[i] <= 1'b0;
      repeat (5) @(posedge sys_clk);
      // for io reads the input buffer opens only on the read ack
      q = (i == 8 && io_read_ack_n) ? ~host_data_out : host_data_out;
      host_pins[i] <= 1'b1;
      repeat (5) @(posedge sys_clk);
      host_data_in <= ~d;
   endtask
endmodule

// [card_host_strobe_handshake_tb.sv]
`define CHK(got, exp) begin \
   samples_checked++; \
   if ((got) !== (exp)) begin \
      bad_count++; \
      $display("CHECK FAILED at %0t got %h expected %h", \
         $time, got, exp); \
   end \
end

module card_host_strobe_handshake_tb
   import strobe_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int IO_READ_STROBE_N = 8, IO_WRITE_STROBE_N = 7, OE = 6, DRD = 5, DWR = 4, GNT = 3;
   logic sys_clk = 1'b0, reset_n = 1'b0, device_selected = 1'b0;
   logic reset_held = 1'b0, tf_on = 1'b0, write_to_taskfile;
   logic io_addr_hit = 1'b0, io_configured = 1'b0, level_irq_mode = 1'b0;
   logic irq_event = 1'b0, busy_in = 1'b0, dma_in_valid = 1'b0;
   logic dma_to_host = 1'b0, dma_active = 1'b0, dma_more_data = 1'b0;
   logic [15:0] read_data = 16'h0000, dma_in_data = 16'h0000;
   logic [15:0] host_data_in, dma_out_data, host_data_out, write_data;
   logic [15:0] got, d;
   logic dma_in_ready, dma_out_valid, io_read_ack_n, dma_request;
   logic dma_request_oe, ready_busy_n, host_data_oe, write_strobe;
   host_strobes_t host_pins;
   card_mode_t card_mode;
   int bad_count = 0, samples_checked = 0, n;
   logic [15:0] wq[$], fq[$];

   initial begin
      forever #50 sys_clk = ~sys_clk;
   end

   card_host_strobe_handshake #(.READY_DELAY_CYC(2), .IRQ_PULSE_CYC(2))
   u_dut (
      .sys_clk, .reset_n, .reset_held_at_powerup(reset_held), .host_pins,
      .host_data_in, .device_selected, .io_addr_hit, .io_configured,
      .level_irq_mode, .irq_event, .busy_in, .read_data, .dma_in_valid,
      .dma_in_ready, .dma_in_data, .dma_to_host, .dma_active,
      .dma_more_data, .dma_out_data, .dma_out_valid, .io_read_ack_n,
      .io_read_ack_oe(), .dma_request, .dma_request_oe, .ready_busy_n,
      .host_data_out, .host_data_oe, .write_data, .write_strobe,
      .write_to_taskfile, .write_to_ctrl_block(), .read_kind(),
      .card_mode);
   host_socket_model u_host (.sys_clk, .io_read_ack_n, .host_data_out,
      .host_pins, .host_data_in);

   // every word leaving the card must be one the host actually sent
   always @(posedge sys_clk) begin
      if (write_strobe === 1'b1) begin
         `CHK({wq.size() != 0, write_data}, {1'b1, wq[0]})
         `CHK(write_to_taskfile, tf_on)
         void'(wq.pop_front());
      end
      if (dma_out_valid === 1'b1) begin
         `CHK({wq.size() != 0, dma_out_data}, {1'b1, wq[0]})
         void'(wq.pop_front());
      end
   end

   task automatic tick(input int k);
      repeat (k) @(posedge sys_clk);
   endtask
   task automatic do_reset(input logic ide);
      u_host.hold(OE, !ide);
      reset_n <= 1'b0;
      tick(16);
      reset_n <= 1'b1;
      tick(20);
   endtask
   task automatic wrap_up;
      if (bad_count == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   initial begin
      #2000000;
      bad_count++;
      wrap_up;
   end

   initial begin
      void'($urandom(32'hFA26));
      do_reset(1'b0);
      `CHK(card_mode, memory_card_mode)
      `CHK(ready_busy_n, 1'b1)
      busy_in <= 1'b1;
      tick(4);
      `CHK(ready_busy_n, 1'b0)
      busy_in <= 1'b0;
      io_addr_hit <= 1'b1;
      u_host.hold(0, 1'b0);
      u_host.pulse(IO_WRITE_STROBE_N, 16'h5A5A, got);
      io_configured <= 1'b1;
      tick(4);
      `CHK(card_mode, io_card_mode)
      for (n = 0; n < 4; n++) begin
         d = 16'($urandom);
         wq.push_back(d);
         u_host.pulse(IO_WRITE_STROBE_N, d, got);
      end
      read_data <= 16'($urandom);
      u_host.pulse(IO_READ_STROBE_N, 16'h0000, got);
      `CHK(got, read_data)
      `CHK(io_read_ack_n, 1'b1)
      level_irq_mode <= 1'b1;
      irq_event <= 1'b1;
      tick(6);
      `CHK(ready_busy_n, 1'b0)
      irq_event <= 1'b0;
      level_irq_mode <= 1'b0;
      tick(6);
      irq_event <= 1'b1;
      tick(3);
      `CHK(ready_busy_n, 1'b0)
      tick(7);
      `CHK(ready_busy_n, 1'b1)
      irq_event <= 1'b0;
      io_configured <= 1'b0;
      u_host.hold(0, 1'b1);
      do_reset(1'b1);
      `CHK(card_mode, ide_mode)
      device_selected <= 1'b1;
      dma_in_valid <= 1'b1;
      dma_in_data <= 16'($urandom);
      for (n = 0; n < 20; n++) begin
         @(posedge sys_clk);
         if (dma_in_ready === 1'b1) begin
            fq.push_back(dma_in_data);
            dma_in_data <= 16'($urandom);
         end
      end
      dma_in_valid <= 1'b0;
      `CHK(fq.size(), 16)
      dma_to_host <= 1'b1;
      dma_more_data <= 1'b1;
      dma_active <= 1'b1;
      tick(6);
      `CHK({dma_request, dma_request_oe}, 2'b11)
      u_host.hold(GNT, 1'b0);
      repeat (16) begin
         u_host.pulse(DRD, 16'h0000, got);
         `CHK(got, fq.pop_front())
      end
      `CHK(dma_request, 1'b0)
      dma_more_data <= 1'b0;
      u_host.hold(GNT, 1'b1);
      tick(6);
      `CHK(dma_request, 1'b0)
      dma_to_host <= 1'b0;
      u_host.hold(GNT, 1'b0);
      d = 16'($urandom);
      wq.push_back(d);
      u_host.pulse(DWR, d, got);
      `CHK(wq.size(), 0)
      // refused: a chip select low during dma, then no dma in progress
      u_host.hold(2, 1'b0);
      u_host.pulse(DWR, 16'h4321, got);
      u_host.hold(2, 1'b1);
      dma_active <= 1'b0;
      u_host.pulse(DWR, 16'h1234, got);
      `CHK(wq.size(), 0)
      u_host.hold(2, 1'b0);
      tf_on <= 1'b1;
      d = 16'($urandom);
      wq.push_back(d);
      u_host.pulse(IO_WRITE_STROBE_N, d, got);
      u_host.hold(2, 1'b1);
      `CHK(wq.size(), 0)
      tf_on <= 1'b0;
      device_selected <= 1'b0;
      tick(6);
      `CHK(dma_request_oe, 1'b0)
      irq_event <= 1'b1;
      tick(6);
      `CHK(ready_busy_n, 1'b1)
      irq_event <= 1'b0;
      tick(6);
      `CHK(ready_busy_n, 1'b0)
      reset_held <= 1'b1;
      busy_in <= 1'b1;
      do_reset(1'b0);
      `CHK(card_mode, memory_card_mode)
      `CHK(ready_busy_n, 1'b1)
      wrap_up;
   end
endmodule
